// *** rtl/pmd_pkg.sv ***
package pmd_pkg;
  localparam int CLS_HI = 15;
  localparam int CLS_LO = 13;
  localparam int OP_HI = 12;
  localparam int OP_LO = 10;
  localparam int LOP_HI = 11;
  localparam int DST_BIT = 9;
  localparam int SRC_HI = 8;
  localparam int SRC_LO = 7;
  localparam int MK_HI = 6;
  localparam int MK_LO = 5;
  localparam int PREG_HI = 4;
  localparam int PREG_LO = 3;
  localparam int MREG_HI = 4;
  localparam int MREG_LO = 2;
  localparam int PPTR_BIT = 2;
  localparam int UPD1_BIT = 1;
  localparam int UPD2_BIT = 0;
  localparam int MPTR_HI = 1;
  localparam int MPTR_LO = 0;
  localparam logic [1:0] DUAL_PTR = 2'h3;
  localparam logic [1:0] LEA_BAD = 2'h3;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] STEP_INC = 16'h0001;
  localparam logic [15:0] STEP_DEC = 16'hffff;
  localparam logic [31:0] ROUND_BIAS = 32'h0000_8000;
  localparam logic [31:0] ROUND_MASK = 32'hffff_0000;
  localparam logic [15:0] LOW_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    CL_ARITH, CL_LOGIC, CL_BITFIELD, CL_JUMP, CL_ADDR_LOAD, CL_MOVE, CL_PMOVE, CL_RSVD
  } pmd_class_t;

  typedef enum logic [1:0] {MK_NONE, MK_READ, MK_WRITE, MK_DUAL} pmd_mkind_t;

  typedef enum logic [2:0] {
    AM_IND, AM_POSTINC, AM_POSTDEC, AM_POSTN, AM_INDEXN, AM_OFFSET, AM_ABS, AM_RSVD
  } pmd_amode_t;

  typedef enum logic [2:0] {RG_X0, RG_Y0, RG_Y1, RG_A1, RG_B1, RG_N, RG_R0, RG_R1} pmd_reg_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_CMP, ALU_NEG, ALU_MPY, ALU_MPYR, ALU_MAC, ALU_MACR,
    ALU_AND, ALU_OR, ALU_EOR, ALU_NOT, ALU_R12, ALU_R13, ALU_R14, ALU_R15
  } pmd_alu_op_t;

  typedef enum {ST_FIRST, ST_EXT1, ST_EXT2, ST_PDATA} pmd_state_t;
endpackage

// *** rtl/pmd_alu.sv ***
`timescale 1ns/1ns
module pmd_alu import pmd_pkg::*; (
  input pmd_alu_op_t op_i,
  input wire logic [31:0] acc_i,
  input wire logic [31:0] addend_i,
  input wire logic [15:0] mul_a_i,
  input wire logic [15:0] mul_b_i,
  output logic [31:0] result_o,
  output logic write_o
);
  logic [31:0] ma;
  logic [31:0] mb;
  logic [31:0] prod;
  logic [31:0] macc;

  assign ma = {{16{mul_a_i[15]}}, mul_a_i};
  assign mb = {{16{mul_b_i[15]}}, mul_b_i};
  // Fractional product: the doubled result keeps the binary point aligned with the accumulator.
  assign prod = (ma * mb) << 1;
  assign macc = acc_i + prod;

  always_comb begin
    result_o = acc_i;
    write_o = 1'b1;
    unique case (op_i)
      ALU_ADD: result_o = acc_i + addend_i;
      ALU_SUB: result_o = acc_i - addend_i;
      ALU_CMP: begin
        result_o = acc_i - addend_i;
        write_o = 1'b0;
      end
      ALU_NEG: result_o = ACC_RESET - acc_i;
      ALU_MPY: result_o = prod;
      ALU_MPYR: result_o = (prod + ROUND_BIAS) & ROUND_MASK; // RQ3
      ALU_MAC: result_o = macc;
      ALU_MACR: result_o = (macc + ROUND_BIAS) & ROUND_MASK; // RQ3
      ALU_AND: result_o = {acc_i[31:16] & addend_i[31:16], acc_i[15:0]};
      ALU_OR: result_o = {acc_i[31:16] | addend_i[31:16], acc_i[15:0]};
      ALU_EOR: result_o = {acc_i[31:16] ^ addend_i[31:16], acc_i[15:0]};
      ALU_NOT: result_o = {~acc_i[31:16], acc_i[15:0]};
      default: write_o = 1'b0;
    endcase
  end
endmodule

// *** rtl/pmd_decoder.sv ***
`timescale 1ns/1ns
// Overview of operation
// [RQ1] Arithmetic plus one memory move, one cycle.
// [RQ2] Arithmetic plus two X reads, one cycle.
// [RQ3] Dual-read multiply optionally rounds its result.
// [RQ4] Parallel moves only with arithmetic operations.
// [RQ5] Parallel moves use restricted registers and modes.
// [RQ6] Instructions span one to three words.
// [RQ7] Each extra word costs one cycle.
// [RQ8] Memory moves offer seven addressing modes.
// [RQ9] Pointer post-updates follow the memory access.
// [RQ10] ALU, transfers, decode and fetch share cycle.
// [RQ11] First transfer global bus, second secondary.
// [RQ12] Logic, bit-field, jumps use no parallel resources.
// [RQ13] Jump target is the second word.
// [RQ14] Memory write stores pre-update register value.
module pmd_decoder import pmd_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic [15:0] program_data_bus_addr_o,
  input wire logic [15:0] program_data_bus_rdata_i,
  output logic program_data_bus_we_o,
  output logic [15:0] program_data_bus_wdata_o,
  output logic [15:0] core_global_data_bus_addr_o,
  output logic core_global_data_bus_rd_o,
  output logic core_global_data_bus_we_o,
  output logic [15:0] core_global_data_bus_wdata_o,
  input wire logic [15:0] core_global_data_bus_rdata_i,
  output logic [15:0] secondary_x_data_bus_addr_o,
  output logic secondary_x_data_bus_rd_o,
  input wire logic [15:0] secondary_x_data_bus_rdata_i,
  output logic [31:0] acc_a_o,
  output logic [31:0] acc_b_o,
  output logic done_o,
  output logic illegal_o
);
  pmd_state_t state_reg;
  logic [15:0] pc_reg;
  logic [15:0] ir_reg;
  logic [15:0] ext_reg;
  logic [15:0] x0_reg;
  logic [15:0] y0_reg;
  logic [15:0] y1_reg;
  logic [15:0] n_reg;
  logic [15:0] ptr_reg [4];
  logic [31:0] acc_a_reg;
  logic [31:0] acc_b_reg;
  logic done_reg;
  logic illegal_reg;

  logic [15:0] iw;
  pmd_class_t cls;
  pmd_mkind_t mk;
  pmd_amode_t amode;
  pmd_reg_t mreg;
  pmd_reg_t preg;
  logic long_move;
  logic bad;
  logic first_ok;
  logic ex_arith;
  logic ex_logic;
  logic ex_lea;
  logic ex_move;
  logic ex_bf;
  logic ex_pm;
  logic ex_jump;
  logic [15:0] ptr_p;
  logic [15:0] ptr_m;
  logic [15:0] mem_ea;
  logic load_en;
  pmd_reg_t load_sel;
  logic [15:0] load_val;
  logic upd_en;
  logic [1:0] upd_idx;
  logic [15:0] upd_step;
  pmd_alu_op_t alu_op;
  logic dst_b;
  logic [31:0] acc_dst;
  logic [31:0] acc_oth;
  logic [31:0] addend;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic [31:0] alu_res;
  logic alu_wr;
  logic alu_fire;

  function automatic logic [15:0] reg_val(input pmd_reg_t s);
    logic [15:0] v;
    v = WORD_RESET;
    unique case (s)
      RG_X0: v = x0_reg;
      RG_Y0: v = y0_reg;
      RG_Y1: v = y1_reg;
      RG_A1: v = acc_a_reg[31:16];
      RG_B1: v = acc_b_reg[31:16];
      RG_N: v = n_reg;
      RG_R0: v = ptr_reg[0];
      RG_R1: v = ptr_reg[1];
    endcase
    return v;
  endfunction

  // The first word is decoded straight off the fetch port; later words reuse the latched opcode.
  assign iw = (state_reg == ST_FIRST) ? program_data_bus_rdata_i : ir_reg; // RQ6
  assign cls = pmd_class_t'(iw[CLS_HI:CLS_LO]);
  assign mk = pmd_mkind_t'(iw[MK_HI:MK_LO]);
  assign amode = pmd_amode_t'(iw[OP_HI:OP_LO]);
  assign mreg = pmd_reg_t'(iw[MREG_HI:MREG_LO]);
  assign preg = pmd_reg_t'({1'b0, iw[PREG_HI:PREG_LO]}); // RQ5
  assign long_move = (amode == AM_OFFSET) || (amode == AM_ABS);

  assign bad = ((cls != CL_ARITH) && (mk != MK_NONE)) // RQ4
    || (cls == CL_RSVD)
    || ((cls == CL_MOVE) && (amode == AM_RSVD)) // RQ8
    || ((cls == CL_LOGIC) && iw[OP_HI])
    || ((cls == CL_ADDR_LOAD) && (iw[MPTR_HI:MPTR_LO] == LEA_BAD));
  assign first_ok = (state_reg == ST_FIRST) && !bad;
  assign ex_arith = first_ok && (cls == CL_ARITH); // RQ1 RQ2
  assign ex_logic = first_ok && (cls == CL_LOGIC);
  assign ex_lea = first_ok && (cls == CL_ADDR_LOAD);
  assign ex_move = (first_ok && (cls == CL_MOVE) && !long_move) || ((state_reg == ST_EXT1) && (cls == CL_MOVE));
  assign ex_jump = (state_reg == ST_EXT1) && (cls == CL_JUMP);
  assign ex_bf = (state_reg == ST_EXT2);
  assign ex_pm = (state_reg == ST_PDATA);

  // The first parallel transfer may only address through R0 or R1, the dual read's second through ptr_reg[DUAL_PTR]; the full move reaches every pointer.
  assign ptr_p = ptr_reg[{1'b0, iw[PPTR_BIT]}]; // RQ5
  assign ptr_m = ptr_reg[iw[MPTR_HI:MPTR_LO]];

  always_comb begin
    mem_ea = ptr_m;
    unique case (amode) // RQ8
      AM_INDEXN: mem_ea = ptr_m + n_reg;
      AM_OFFSET: mem_ea = ptr_m + program_data_bus_rdata_i;
      AM_ABS: mem_ea = program_data_bus_rdata_i;
      default: mem_ea = ptr_m;
    endcase
  end

  // Memory ports are combinational because the access completes inside the issuing cycle.
  always_comb begin
    core_global_data_bus_addr_o = WORD_RESET;
    core_global_data_bus_rd_o = 1'b0;
    core_global_data_bus_we_o = 1'b0;
    core_global_data_bus_wdata_o = WORD_RESET;
    if (ex_arith && (mk != MK_NONE)) begin // RQ11
      core_global_data_bus_addr_o = ptr_p;
      core_global_data_bus_rd_o = (mk != MK_WRITE);
      core_global_data_bus_we_o = (mk == MK_WRITE);
      core_global_data_bus_wdata_o = reg_val(preg); // RQ14
    end else if (ex_move) begin
      core_global_data_bus_addr_o = mem_ea;
      core_global_data_bus_rd_o = !iw[DST_BIT];
      core_global_data_bus_we_o = iw[DST_BIT];
      core_global_data_bus_wdata_o = reg_val(mreg);
    end else if (ex_bf) begin
      core_global_data_bus_addr_o = program_data_bus_rdata_i;
      core_global_data_bus_rd_o = 1'b1;
      core_global_data_bus_we_o = 1'b1;
      core_global_data_bus_wdata_o = core_global_data_bus_rdata_i | ext_reg;
    end
  end

  assign secondary_x_data_bus_rd_o = ex_arith && (mk == MK_DUAL); // RQ2 RQ11 RQ12
  assign secondary_x_data_bus_addr_o = secondary_x_data_bus_rd_o ? ptr_reg[DUAL_PTR] : WORD_RESET;
  // The data cycle takes its pointer from the latched opcode, so the fetch address never loops through read data.
  assign program_data_bus_addr_o = ex_pm ? ptr_reg[ir_reg[MPTR_HI:MPTR_LO]] : pc_reg; // RQ11
  assign program_data_bus_we_o = ex_pm && iw[DST_BIT];
  assign program_data_bus_wdata_o = ex_pm ? reg_val(mreg) : WORD_RESET;

  always_comb begin
    load_en = 1'b0;
    load_sel = preg;
    load_val = core_global_data_bus_rdata_i;
    if (ex_arith && ((mk == MK_READ) || (mk == MK_DUAL))) begin
      load_en = 1'b1;
    end else if (ex_move && !iw[DST_BIT]) begin
      load_en = 1'b1;
      load_sel = mreg;
    end else if (ex_pm && !iw[DST_BIT]) begin
      load_en = 1'b1;
      load_sel = mreg;
      load_val = program_data_bus_rdata_i;
    end
  end

  always_comb begin
    upd_en = 1'b0;
    upd_idx = iw[MPTR_HI:MPTR_LO];
    upd_step = STEP_INC;
    if (ex_arith && (mk != MK_NONE)) begin // RQ9
      upd_en = 1'b1;
      upd_idx = {1'b0, iw[PPTR_BIT]};
      upd_step = iw[UPD1_BIT] ? n_reg : STEP_INC;
    end else if (ex_move) begin
      upd_en = (amode == AM_POSTINC) || (amode == AM_POSTDEC) || (amode == AM_POSTN);
      upd_step = (amode == AM_POSTN) ? n_reg : ((amode == AM_POSTDEC) ? STEP_DEC : STEP_INC);
    end else if (ex_pm) begin
      upd_en = 1'b1;
    end else if (ex_lea) begin
      upd_en = 1'b1;
      upd_idx = iw[PREG_HI:PREG_LO];
      upd_step = iw[MPTR_LO] ? STEP_DEC : (iw[MPTR_HI] ? n_reg : STEP_INC);
    end
  end

  assign alu_op = (cls == CL_LOGIC) ? pmd_alu_op_t'({2'b10, iw[LOP_HI:OP_LO]})
                                    : pmd_alu_op_t'({1'b0, iw[OP_HI:OP_LO]});
  assign dst_b = iw[DST_BIT];
  assign acc_dst = dst_b ? acc_b_reg : acc_a_reg;
  assign acc_oth = dst_b ? acc_a_reg : acc_b_reg;

  always_comb begin
    addend = acc_oth;
    mul_a = x0_reg;
    mul_b = y0_reg;
    unique case (iw[SRC_HI:SRC_LO])
      2'h0: addend = {x0_reg, LOW_ZERO};
      2'h1: begin
        addend = {y0_reg, LOW_ZERO};
        mul_b = y1_reg;
      end
      2'h2: begin
        addend = {y1_reg, LOW_ZERO};
        mul_a = y0_reg;
        mul_b = y1_reg;
      end
      2'h3: begin
        addend = acc_oth;
        mul_a = y1_reg;
        mul_b = y1_reg;
      end
    endcase
  end

  pmd_alu u_alu (
    .op_i(alu_op),
    .acc_i(acc_dst),
    .addend_i(addend),
    .mul_a_i(mul_a),
    .mul_b_i(mul_b),
    .result_o(alu_res),
    .write_o(alu_wr)
  );
  assign alu_fire = (ex_arith || ex_logic) && alu_wr; // RQ1 RQ12

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_FIRST;
      pc_reg <= PC_RESET;
      ir_reg <= WORD_RESET;
      ext_reg <= WORD_RESET;
    end else begin
      unique case (state_reg)
        ST_FIRST: begin
          pc_reg <= pc_reg + STEP_INC; // RQ10
          ir_reg <= program_data_bus_rdata_i;
          if (!bad && (((cls == CL_MOVE) && long_move) || (cls == CL_JUMP) || (cls == CL_BITFIELD))) begin
            state_reg <= ST_EXT1; // RQ7
          end else if (!bad && (cls == CL_PMOVE)) begin
            state_reg <= ST_PDATA;
          end
        end
        ST_EXT1: begin
          pc_reg <= ex_jump ? program_data_bus_rdata_i : pc_reg + STEP_INC; // RQ13
          ext_reg <= program_data_bus_rdata_i;
          state_reg <= (cls == CL_BITFIELD) ? ST_EXT2 : ST_FIRST; // RQ7
        end
        ST_EXT2: begin
          pc_reg <= pc_reg + STEP_INC;
          state_reg <= ST_FIRST;
        end
        ST_PDATA: state_reg <= ST_FIRST;
      endcase
    end
  end

  // A load into a pointer overrides that pointer's post-update in the same cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= WORD_RESET;
      end
      n_reg <= WORD_RESET;
    end else begin
      if (upd_en) begin
        ptr_reg[upd_idx] <= ptr_reg[upd_idx] + upd_step; // RQ9
      end
      if (secondary_x_data_bus_rd_o) begin
        ptr_reg[DUAL_PTR] <= ptr_reg[DUAL_PTR] + (iw[UPD2_BIT] ? STEP_DEC : STEP_INC); // RQ9
      end
      if (load_en && (load_sel == RG_R0)) begin
        ptr_reg[0] <= load_val;
      end
      if (load_en && (load_sel == RG_R1)) begin
        ptr_reg[1] <= load_val;
      end
      if (load_en && (load_sel == RG_N)) begin
        n_reg <= load_val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      x0_reg <= WORD_RESET;
      y0_reg <= WORD_RESET;
      y1_reg <= WORD_RESET;
    end else begin
      if (load_en && (load_sel == RG_X0)) begin
        x0_reg <= load_val;
      end
      if (load_en && (load_sel == RG_Y0)) begin
        y0_reg <= load_val;
      end
      if (load_en && (load_sel == RG_Y1)) begin
        y1_reg <= load_val;
      end
      if (secondary_x_data_bus_rd_o) begin
        x0_reg <= secondary_x_data_bus_rdata_i; // RQ2
      end
    end
  end

  // The ALU result is written last, so it wins over a parallel load into the same accumulator.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_a_reg <= ACC_RESET;
      acc_b_reg <= ACC_RESET;
    end else begin
      if (load_en && (load_sel == RG_A1)) begin
        acc_a_reg[31:16] <= load_val;
      end
      if (load_en && (load_sel == RG_B1)) begin
        acc_b_reg[31:16] <= load_val;
      end
      if (alu_fire && !dst_b) begin
        acc_a_reg <= alu_res; // RQ14
      end
      if (alu_fire && dst_b) begin
        acc_b_reg <= alu_res;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      done_reg <= ex_arith || ex_logic || ex_lea || ex_move || ex_bf || ex_pm || ex_jump;
      illegal_reg <= (state_reg == ST_FIRST) && bad; // RQ4
    end
  end

  assign acc_a_o = acc_a_reg;
  assign acc_b_o = acc_b_reg;
  assign done_o = done_reg;
  assign illegal_o = illegal_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_single_cycle: assert property (ex_arith |=> (state_reg == ST_FIRST) && done_reg) // RQ1
    else $error("parallel move instruction did not finish in one cycle");
  chk_fetch_overlap: assert property (ex_arith |=> program_data_bus_addr_o == $past(pc_reg) + STEP_INC) // RQ10
    else $error("fetch did not advance during arithmetic issue");
  chk_dual_issue: assert property (ex_arith && (mk == MK_DUAL) |->
      core_global_data_bus_rd_o && (secondary_x_data_bus_addr_o == ptr_reg[DUAL_PTR])) // RQ2 RQ11
    else $error("dual read did not use both data buses");
  chk_dual_decr: assert property (ex_arith && (mk == MK_DUAL) && iw[UPD2_BIT] |=>
      ptr_reg[DUAL_PTR] == $past(ptr_reg[DUAL_PTR]) - STEP_INC) // RQ9
    else $error("second pointer not decremented after dual read");
  chk_post_offset: assert property (ex_arith && (mk != MK_NONE) && iw[UPD1_BIT] |=>
      ptr_reg[$past(upd_idx)] == $past(ptr_reg[upd_idx]) + $past(n_reg)) // RQ9
    else $error("pointer not post-updated by offset");
  chk_round_result: assert property (ex_arith && ((alu_op == ALU_MPYR) || (alu_op == ALU_MACR)) |=>
      ($past(dst_b) ? acc_b_reg[15:0] : acc_a_reg[15:0]) == LOW_ZERO) // RQ3
    else $error("rounded multiply left low word set");
  chk_move_refused: assert property ((state_reg == ST_FIRST) && (cls != CL_ARITH) && (mk != MK_NONE) |->
      !core_global_data_bus_rd_o && !core_global_data_bus_we_o ##1 illegal_reg && !done_reg) // RQ4
    else $error("parallel move accepted on non-arithmetic instruction");
  chk_parallel_ptr: assert property (ex_arith && (mk != MK_NONE) |->
      (core_global_data_bus_addr_o == ptr_reg[0]) || (core_global_data_bus_addr_o == ptr_reg[1])) // RQ5
    else $error("parallel move used a pointer outside its subset");
  chk_bf_length: assert property (first_ok && (cls == CL_BITFIELD) |=>
      (state_reg == ST_EXT1) ##1 (state_reg == ST_EXT2) ##1 (state_reg == ST_FIRST)) // RQ6 RQ7
    else $error("three word instruction took the wrong number of cycles");
  chk_mode_reserved: assert property ((state_reg == ST_FIRST) && (cls == CL_MOVE) && (amode == AM_RSVD) |=>
      illegal_reg) // RQ8
    else $error("eighth addressing mode was accepted");
  chk_logic_quiet: assert property (ex_logic || ex_jump |->
      !secondary_x_data_bus_rd_o && !core_global_data_bus_rd_o && !core_global_data_bus_we_o) // RQ12
    else $error("logic or jump instruction used a data bus");
  chk_jump_target: assert property (ex_jump |=> pc_reg == $past(program_data_bus_rdata_i)) // RQ13
    else $error("jump did not load target from second word");
  chk_write_old: assert property (ex_arith && (mk == MK_WRITE) && (preg == RG_A1) && !dst_b && alu_wr |->
      core_global_data_bus_wdata_o == acc_a_reg[31:16] ##1 acc_a_reg == $past(alu_res)) // RQ14
    else $error("parallel write did not store the old register value");
endmodule

// *** tb/pmd_mem.sv ***
`timescale 1ns/1ns
module pmd_mem (
  input wire logic clk_i,
  input wire logic [15:0] p_addr_i,
  output logic [15:0] p_rdata_o,
  input wire logic p_we_i,
  input wire logic [15:0] p_wdata_i,
  input wire logic [15:0] g_addr_i,
  input wire logic g_rd_i,
  input wire logic g_we_i,
  input wire logic [15:0] g_wdata_i,
  output logic [15:0] g_rdata_o,
  input wire logic [15:0] s_addr_i,
  input wire logic s_rd_i,
  output logic [15:0] s_rdata_o
);
  logic [15:0] pmem [0:65535];
  logic [15:0] xmem [0:65535];
  logic [15:0] junk_reg = 16'h5a3c;
  // Ports that are not strobed show a moving pattern, so data taken without a read strobe is caught.
  always @(posedge clk_i) begin
    junk_reg <= {junk_reg[14:0], junk_reg[15]} ^ 16'h0001;
  end
  assign p_rdata_o = pmem[p_addr_i];
  assign g_rdata_o = g_rd_i ? xmem[g_addr_i] : junk_reg;
  assign s_rdata_o = s_rd_i ? xmem[s_addr_i] : ~junk_reg;
  // A plain process, because the bench preloads both arrays from outside.
  always @(posedge clk_i) begin
    if (p_we_i) begin
      pmem[p_addr_i] <= p_wdata_i;
    end
    if (g_we_i) begin
      xmem[g_addr_i] <= g_wdata_i;
    end
  end
endmodule

// *** tb/parallel_move_decoder_bench.sv ***
`timescale 1ns/1ns
module parallel_move_decoder_bench;
  localparam logic [15:0] PROG [0:28] = '{16'hb800, 16'h0010, 16'hb804, 16'h0011, 16'hb814, 16'h0012,
    16'hb81c, 16'h0030, 16'hb818, 16'h0031, 16'h105e, 16'h1e71, 16'hba08, 16'h0060, 16'hba00, 16'h0061,
    16'hba18, 16'h0062, 16'hba1c, 16'h0063, 16'h2020, 16'h4020, 16'h6020, 16'h8020, 16'h4000, 16'h00f0,
    16'h0070, 16'h6000, 16'h0050};
  localparam int LENS [0:20] = '{2, 2, 2, 2, 2, 1, 1, 2, 2, 2, 2, 1, 1, 1, 1, 3, 2, 2, 1, 1, 2};
  logic clk_i;
  logic sys_rst_i;
  logic [15:0] p_addr, p_rdata, p_wdata, g_addr, g_wdata, g_rdata, s_addr, s_rdata;
  logic p_we, g_rd, g_we, s_rd, done, illegal;
  logic [31:0] acc_a, acc_b;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int ev_cyc[$];
  logic ev_ill[$];
  int s_rd_cnt = 0;
  int p_we_cnt = 0;
  logic [15:0] s_addr_seen, g_addr_seen, pw_addr, pw_data;
  logic g_rd_seen;

  pmd_decoder i_pmd_decoder (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .program_data_bus_addr_o(p_addr), .program_data_bus_rdata_i(p_rdata),
    .program_data_bus_we_o(p_we), .program_data_bus_wdata_o(p_wdata),
    .core_global_data_bus_addr_o(g_addr), .core_global_data_bus_rd_o(g_rd),
    .core_global_data_bus_we_o(g_we), .core_global_data_bus_wdata_o(g_wdata),
    .core_global_data_bus_rdata_i(g_rdata),
    .secondary_x_data_bus_addr_o(s_addr), .secondary_x_data_bus_rd_o(s_rd),
    .secondary_x_data_bus_rdata_i(s_rdata),
    .acc_a_o(acc_a), .acc_b_o(acc_b), .done_o(done), .illegal_o(illegal)
  );

  pmd_mem i_pmd_mem (
    .clk_i(clk_i), .p_addr_i(p_addr), .p_rdata_o(p_rdata), .p_we_i(p_we), .p_wdata_i(p_wdata),
    .g_addr_i(g_addr), .g_rd_i(g_rd), .g_we_i(g_we), .g_wdata_i(g_wdata), .g_rdata_o(g_rdata),
    .s_addr_i(s_addr), .s_rd_i(s_rd), .s_rdata_o(s_rdata)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Sampling on the falling edge sees every output settled for the current cycle.
  always @(negedge clk_i) begin
    cyc = cyc + 1;
    if (sys_rst_i === 1'b0) begin
      if (done === 1'b1 || illegal === 1'b1) begin
        ev_cyc.push_back(cyc);
        ev_ill.push_back(illegal);
      end
      if (s_rd === 1'b1) begin
        s_rd_cnt++;
        s_addr_seen = s_addr;
        g_addr_seen = g_addr;
        g_rd_seen = g_rd;
      end
      if (p_we === 1'b1) begin
        p_we_cnt++;
        pw_addr = p_addr;
        pw_data = p_wdata;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic load_memories;
    for (int i = 0; i < 65536; i++) begin
      i_pmd_mem.pmem[i] = 16'h0000;
      i_pmd_mem.xmem[i] = 16'h0000;
    end
    for (int i = 0; i < 29; i++) begin
      i_pmd_mem.pmem[i] = PROG[i];
    end
    i_pmd_mem.pmem[16'h0050] = 16'hc201;
    i_pmd_mem.pmem[16'h0051] = 16'h2800;
    i_pmd_mem.pmem[16'h0052] = 16'hbc00;
    i_pmd_mem.pmem[16'h0053] = 16'h6000;
    i_pmd_mem.pmem[16'h0054] = 16'h0053;
    i_pmd_mem.xmem[16'h0000] = 16'h1234;
    i_pmd_mem.xmem[16'h0010] = 16'h4000;
    i_pmd_mem.xmem[16'h0011] = 16'h2001;
    i_pmd_mem.xmem[16'h0012] = 16'h0002;
    i_pmd_mem.xmem[16'h0030] = 16'h0040;
    i_pmd_mem.xmem[16'h0031] = 16'h0050;
    i_pmd_mem.xmem[16'h0040] = 16'hdead;
    i_pmd_mem.xmem[16'h0050] = 16'h5a5a;
    i_pmd_mem.xmem[16'h0070] = 16'h0f01;
  endtask

  task automatic scn_issue_timing;
    int n;
    n = 0;
    while (ev_cyc.size() < 21 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (ev_cyc.size() < 21) begin
      bad_count++;
      $display("[ERR] %0t program did not complete", $time);
    end else begin
      for (int k = 1; k < 21; k++) begin
        check(32'(ev_cyc[k] - ev_cyc[k - 1]), 32'(LENS[k]));
        check({31'h0, ev_ill[k]}, {31'h0, ((k >= 11 && k <= 14) || (k == 19))});
      end
    end
  endtask

  task automatic scn_single_move;
    check(acc_a, 32'h0234_8000);
    check({16'h0000, i_pmd_mem.xmem[16'h0040]}, 32'h0000_0000);
    check({16'h0000, i_pmd_mem.xmem[16'h0063]}, 32'h0000_0042);
  endtask

  task automatic scn_dual_read;
    check(acc_b, 32'h1001_0000);
    check({16'h0000, i_pmd_mem.xmem[16'h0060]}, 32'h0000_5a5a);
    check({16'h0000, i_pmd_mem.xmem[16'h0061]}, 32'h0000_1234);
    check({16'h0000, i_pmd_mem.xmem[16'h0062]}, 32'h0000_0051);
    check(32'(s_rd_cnt), 32'h0000_0001);
    check({16'h0000, s_addr_seen}, 32'h0000_0000);
    check({16'h0000, g_addr_seen}, 32'h0000_0050);
    check({31'h0, g_rd_seen}, 32'h0000_0001);
  endtask

  task automatic scn_control_and_program;
    check({16'h0000, i_pmd_mem.xmem[16'h0070]}, 32'h0000_0ff1);
    check(32'(p_we_cnt), 32'h0000_0001);
    check({16'h0000, pw_addr}, 32'h0000_0042);
    check({16'h0000, pw_data}, 32'h0000_1234);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    load_memories;
    repeat (8) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    scn_issue_timing;
    scn_single_move;
    scn_dual_read;
    scn_control_and_program;
    end_of_test;
  end
endmodule
